// ===== rtl/bcc_config_regs.sv
// Configuration register pair for one biopotential acquisition channel.
// Assumes the serial port decoder delivers one-cycle write strobes and a
// combinational read address; master tick select comes from elsewhere.
//
// Behaviour
// - Bit 23 inverts input polarity, resets 0
// - Bit 21 isolates positive electrode, resets 1
// - Bit 20 isolates negative electrode, resets 1
// - 32768 Hz tick: codes give 512/256/128 sps
// - First 32000 Hz tick: codes give 500/250/125
// - Speed field resets 10; rate needs tick
// - Gain bits 17:16 select 20..160 V/V
// - Bit 14 enables 0.5 Hz high-pass, resets 1
// - Low-pass bits 13:12: bypass/40/100/150, resets 01
// - 100 Hz only at 512/256/500/250 sps
// - 150 Hz only at 512/500 sps
// - Unsupported low-pass code runs as 40 Hz
// - Stored value kept; readback shows effective code
// - Changes may break sample stream continuity
`timescale 1ns/1ps
module bcc_config_regs (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        clk_en_i,
	// Register port
	input  wire logic [6:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [23:0] reg_wdata_i,
	output logic      [23:0] reg_rdata_o,
	output logic             reg_hit_o,
	// Timing selection from the general configuration
	input  wire logic [1:0]  master_tick_select_i,
	// Analog and filter controls
	output logic             input_polarity_invert_o,
	output logic             positive_input_isolate_o,
	output logic             negative_input_isolate_o,
	output logic [1:0]       sample_rate_code_o,
	output logic [1:0]       gain_code_o,
	output logic [7:0]       gain_vv_o,
	output logic             highpass_filter_on_o,
	output logic [1:0]       lowpass_cutoff_select_o,
	output logic             config_changed_o
);

	////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic       input_polarity_invert;
		logic       open_p;
		logic       open_n;
		logic [1:0] rate;
		logic [1:0] gain;
		logic       hpf;
		logic [1:0] lpf;
		logic       changed;
	} bcc_state_s;

	bcc_state_s state_reg;
	bcc_state_s state_next;
	logic [1:0] lpf_eff;
	logic [23:0] ch_word;

	bcc_lpf_map u_lpf_map (
		.master_tick_select_i (master_tick_select_i),
		.rate_i               (state_reg.rate),
		.lowpass_req_i        (state_reg.lpf),
		.lowpass_eff_o        (lpf_eff)
	);

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		state_next = state_reg;
		state_next.changed = 1'h0;
		if (reg_wr_i && reg_addr_i == bcc_pkg::ADDR_INPUT_SWITCH_CONFIG) begin
			state_next.input_polarity_invert    = reg_wdata_i[bcc_pkg::POS_POLARITY_INVERT];
			state_next.open_p = reg_wdata_i[bcc_pkg::POS_POSITIVE_ISOLATE];
			state_next.open_n = reg_wdata_i[bcc_pkg::POS_NEGATIVE_ISOLATE];
		end
		if (reg_wr_i && reg_addr_i == bcc_pkg::ADDR_CHANNEL_CONFIG) begin
			// Rate code 11 is trusted not to arrive; it is stored as is
			state_next.rate = reg_wdata_i[bcc_pkg::POS_RATE_LO +: 2];
			state_next.gain = reg_wdata_i[bcc_pkg::POS_GAIN_LO +: 2];
			state_next.hpf  = reg_wdata_i[bcc_pkg::POS_HIGHPASS];
			state_next.lpf  = reg_wdata_i[bcc_pkg::POS_LOWPASS_LO +: 2];
			// Downstream may flush its pipeline; no continuity is kept
			state_next.changed = 1'h1;
		end
		if (!rst_n_i) begin
			state_next.input_polarity_invert     = bcc_pkg::RST_POLARITY_INVERT;
			state_next.open_p  = bcc_pkg::RST_POSITIVE_ISOLATE;
			state_next.open_n  = bcc_pkg::RST_NEGATIVE_ISOLATE;
			state_next.rate    = bcc_pkg::RST_RATE;
			state_next.gain    = bcc_pkg::RST_GAIN;
			state_next.hpf     = bcc_pkg::RST_HIGHPASS;
			state_next.lpf     = bcc_pkg::RST_LOWPASS;
			state_next.changed = 1'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (clk_en_i || !rst_n_i) begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		ch_word = 24'h000000;
		ch_word[bcc_pkg::POS_RATE_LO +: 2]    = state_reg.rate;
		ch_word[bcc_pkg::POS_GAIN_LO +: 2]    = state_reg.gain;
		ch_word[bcc_pkg::POS_HIGHPASS]        = state_reg.hpf;
		ch_word[bcc_pkg::POS_LOWPASS_LO +: 2] = lpf_eff;
		reg_rdata_o = 24'h000000;
		reg_hit_o   = 1'h1;
		case (reg_addr_i)
			bcc_pkg::ADDR_INPUT_SWITCH_CONFIG: begin
				reg_rdata_o[bcc_pkg::POS_POLARITY_INVERT]  = state_reg.input_polarity_invert;
				reg_rdata_o[bcc_pkg::POS_POSITIVE_ISOLATE] = state_reg.open_p;
				reg_rdata_o[bcc_pkg::POS_NEGATIVE_ISOLATE] = state_reg.open_n;
			end
			bcc_pkg::ADDR_CHANNEL_CONFIG: begin
				reg_rdata_o = ch_word;
			end
			default: begin
				reg_hit_o = 1'h0;
			end
		endcase
	end

	always_comb begin
		input_polarity_invert_o  = state_reg.input_polarity_invert;
		positive_input_isolate_o = state_reg.open_p;
		negative_input_isolate_o = state_reg.open_n;
		sample_rate_code_o       = state_reg.rate;
		gain_code_o              = state_reg.gain;
		gain_vv_o = 8'(bcc_pkg::GAIN_BASE_VV << state_reg.gain);
		highpass_filter_on_o     = state_reg.hpf;
		lowpass_cutoff_select_o  = lpf_eff;
		config_changed_o         = state_reg.changed;
	end

endmodule

// ===== rtl/bcc_pkg.sv
// Package for the biopotential channel configuration register pair.
// Assumes a host reaches the registers by address over the serial port.
package bcc_pkg;

	// Register addresses on the serial register port
	localparam logic [6:0] ADDR_INPUT_SWITCH_CONFIG = 7'h14;
	localparam logic [6:0] ADDR_CHANNEL_CONFIG      = 7'h15;

	// Input switch configuration fields
	localparam int         POS_POLARITY_INVERT   = 23;
	localparam int         POS_POSITIVE_ISOLATE  = 21;
	localparam int         POS_NEGATIVE_ISOLATE  = 20;

	// Channel configuration fields
	localparam int         POS_RATE_LO           = 22;
	localparam int         POS_GAIN_LO           = 16;
	localparam int         POS_HIGHPASS          = 14;
	localparam int         POS_LOWPASS_LO        = 12;

	// Reset values
	localparam logic       RST_POLARITY_INVERT   = 1'h0;
	localparam logic       RST_POSITIVE_ISOLATE  = 1'h1;
	localparam logic       RST_NEGATIVE_ISOLATE  = 1'h1;
	localparam logic [1:0] RST_RATE              = 2'h2;
	localparam logic [1:0] RST_GAIN              = 2'h0;
	localparam logic       RST_HIGHPASS          = 1'h1;
	localparam logic [1:0] RST_LOWPASS           = 2'h1;

	// Master tick selections
	localparam logic [1:0] TICK_32768            = 2'h0;
	localparam logic [1:0] TICK_32000_A          = 2'h1;

	// Sample speed codes
	localparam logic [1:0] RATE_FAST             = 2'h0;
	localparam logic [1:0] RATE_MID              = 2'h1;

	// Low-pass cutoff codes
	localparam logic [1:0] LPF_40HZ              = 2'h1;
	localparam logic [1:0] LPF_100HZ             = 2'h2;
	localparam logic [1:0] LPF_150HZ             = 2'h3;

	// Gain codes select 20 V/V shifted left by the code
	localparam int         GAIN_BASE_VV          = 20;

endpackage

// ===== rtl/bcc_lpf_map.sv
// Maps a requested low-pass code to the code the filter really uses.
// Assumes the tick selection and sample speed are the live register values.
`timescale 1ns/1ps
module bcc_lpf_map (
	// Settings
	input  wire logic [1:0] master_tick_select_i,
	input  wire logic [1:0] rate_i,
	input  wire logic [1:0] lowpass_req_i,
	// Effective code
	output logic      [1:0] lowpass_eff_o
);
	logic fast_tick;
	logic ok_100;
	logic ok_150;

	always_comb begin
		// Only the two high-rate tick selections reach 250 sps and above
		fast_tick = (master_tick_select_i == bcc_pkg::TICK_32768) ||
		            (master_tick_select_i == bcc_pkg::TICK_32000_A);
		ok_100 = fast_tick && ((rate_i == bcc_pkg::RATE_FAST) ||
		                       (rate_i == bcc_pkg::RATE_MID));
		ok_150 = fast_tick && (rate_i == bcc_pkg::RATE_FAST);
		lowpass_eff_o = lowpass_req_i;
		if ((lowpass_req_i == bcc_pkg::LPF_100HZ && !ok_100) ||
		    (lowpass_req_i == bcc_pkg::LPF_150HZ && !ok_150)) begin
			lowpass_eff_o = bcc_pkg::LPF_40HZ;
		end
	end
endmodule

// ===== sim/bcc_checker.sv
// Checker for the channel configuration register pair.
// Assumes it is bound to bcc_config_regs and sees only its ports.
`timescale 1ns/1ps
module bcc_checker (
	// Clock, reset and enable
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        clk_en_i,
	// Register port
	input wire logic        reg_wr_i,
	input wire logic [6:0]  reg_addr_i,
	input wire logic [23:0] reg_wdata_i,
	input wire logic [23:0] reg_rdata_o,
	input wire logic        reg_hit_o,
	// Timing selection
	input wire logic [1:0]  master_tick_select_i,
	// Channel controls
	input wire logic        input_polarity_invert_o,
	input wire logic        positive_input_isolate_o,
	input wire logic        negative_input_isolate_o,
	input wire logic [1:0]  sample_rate_code_o,
	input wire logic [1:0]  gain_code_o,
	input wire logic [7:0]  gain_vv_o,
	input wire logic        highpass_filter_on_o,
	input wire logic [1:0]  lowpass_cutoff_select_o,
	input wire logic        config_changed_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence wr14;
		reg_wr_i && clk_en_i && reg_addr_i == 7'h14;
	endsequence
	sequence wr15;
		reg_wr_i && clk_en_i && reg_addr_i == 7'h15;
	endsequence
	mux_upd_a: assert property (wr14 |=> {input_polarity_invert_o,
		positive_input_isolate_o, negative_input_isolate_o} ==
		{$past(reg_wdata_i[23]), $past(reg_wdata_i[21:20])}) else $error("mux");
	rate_upd_a: assert property (wr15 |=>
		sample_rate_code_o == $past(reg_wdata_i[23:22])) else $error("rate");
	gain_vv_a: assert property (wr15 |=>
		gain_vv_o == 8'h14 << $past(reg_wdata_i[17:16])) else $error("gain");
	lpf_fall_a: assert property (wr15 ##0 reg_wdata_i[13] &&
		reg_wdata_i[23:22] == 2'h2 |=> lowpass_cutoff_select_o == 2'h1)
		else $error("lowpass fallback");
	lpf_top_a: assert property (lowpass_cutoff_select_o == 2'h3 |->
		sample_rate_code_o == 2'h0 && master_tick_select_i < 2'h2)
		else $error("lowpass 150");
	rd_eff_a: assert property (reg_addr_i == 7'h15 |->
		reg_rdata_o[13:12] == lowpass_cutoff_select_o) else $error("readback");
	unused_bits_a: assert property ((reg_rdata_o & (reg_addr_i[0] ?
		24'h3c8fff : 24'h4fffff)) == 24'h0) else $error("unused bits");
	changed_a: assert property (wr15 |=> config_changed_o)
		else $error("change pulse");
	hpf_gain_a: assert property (wr15 |=>
		{highpass_filter_on_o, gain_code_o} ==
		{$past(reg_wdata_i[14]), $past(reg_wdata_i[17:16])})
		else $error("highpass or gain code");
	hit_map_a: assert property (reg_hit_o ==
		(reg_addr_i == 7'h14 || reg_addr_i == 7'h15)) else $error("hit");
	freeze_hold_a: assert property (!clk_en_i |=> $stable({
		input_polarity_invert_o, positive_input_isolate_o,
		negative_input_isolate_o, sample_rate_code_o, gain_code_o,
		highpass_filter_on_o, config_changed_o})) else $error("freeze");
endmodule
bind bcc_config_regs bcc_checker u_bcc_checker (.*);

// ===== sim/bcc_host.sv
// Host model driving the register port.
// Assumes writes are taken on the rising edge, reads are combinational.
`timescale 1ns/1ps
module bcc_host (
	// Clock
	input  wire logic        clk_i,
	// Register port
	input  wire logic [23:0] rdata_i,
	output logic      [6:0]  addr_o,
	output logic             wr_o,
	output logic      [23:0] wdata_o
);
	initial addr_o = 7'h0;
	initial wr_o = 1'h0;
	initial wdata_o = 24'h0;
	// Never sends speed code 11 or reserved speeds
	task wr(input logic [6:0] a, input logic [23:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'h1;
		@(negedge clk_i);
		wr_o = 1'h0;
		wdata_o = ~d; // Stale data would hide a late capture
	endtask
	task rd(input logic [6:0] a, output logic [23:0] d);
		@(negedge clk_i);
		addr_o = a;
		#5 d = rdata_i;
	endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the channel configuration registers.
// Assumes a 20 MHz clock and a host model on the register port.
`timescale 1ns/1ps
module testbench;
	logic        clk_i = 0, rst_n_i = 0, clk_en_i = 1, wr, hit;
	logic [1:0]  tick = 2'h0, lpf, e;
	logic [6:0]  addr;
	logic [23:0] wdata, rdata, d, q;
	logic        input_polarity_invert, opp, opn, hpf, chg;
	logic [1:0]  rate, gcode;
	logic [7:0]  vv;
	int          fail_count = 0, tests_run = 0;
	always #25 clk_i = ~clk_i;
	bcc_host u_bcc_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
		.wr_o(wr), .wdata_o(wdata));
	bcc_config_regs u_bcc_config_regs (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.clk_en_i(clk_en_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_hit_o(hit),
		.master_tick_select_i(tick), .input_polarity_invert_o(input_polarity_invert),
		.positive_input_isolate_o(opp), .negative_input_isolate_o(opn),
		.sample_rate_code_o(rate), .gain_code_o(gcode), .gain_vv_o(vv),
		.highpass_filter_on_o(hpf), .lowpass_cutoff_select_o(lpf),
		.config_changed_o(chg));
	task chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task t_mux;
		u_bcc_host.rd(7'h14, q);
		chk(q, 24'h300000);
		u_bcc_host.rd(7'h15, q);
		chk(q, 24'h805000);
		u_bcc_host.wr(7'h14, 24'hffffff);
		u_bcc_host.rd(7'h14, q);
		chk(q, 24'hb00000);
		chk({21'h0, input_polarity_invert, opp, opn}, 24'h7);
		u_bcc_host.wr(7'h14, 24'h4fffff);
		u_bcc_host.rd(7'h14, q);
		chk(q, 24'h0);
		chk({21'h0, input_polarity_invert, opp, opn}, 24'h0);
		u_bcc_host.wr(7'h16, 24'hffffff);
		u_bcc_host.rd(7'h16, q);
		chk(q, 24'h0);
		chk({23'h0, hit}, 24'h0);
		@(negedge clk_i);
		clk_en_i = 1'h0;
		u_bcc_host.wr(7'h15, 24'h0);
		clk_en_i = 1'h1;
		chk({23'h0, chg}, 24'h0);
		u_bcc_host.rd(7'h15, q);
		chk(q, 24'h805000);
		$display("test mux done");
	endtask
	task t_lpf;
		for (int t = 0; t < 4; t++)
			for (int r = 0; r < 3; r++)
				for (int l = 0; l < 4; l++)
					if (t < 2 || r == 2) begin
						tick = 2'(t);
						d = {r[1:0], 4'h0, l[1:0], 1'b0, l[0], l[1:0], 12'h0};
						u_bcc_host.wr(7'h15, d | 24'h3c8fff);
						chk({23'h0, chg}, 24'h1);
						e = (l == 2 && !(t < 2 && r < 2)) ||
							(l == 3 && !(t < 2 && r == 0)) ? 2'h1 : 2'(l);
						d[13:12] = e;
						u_bcc_host.rd(7'h15, q);
						chk(q, d);
						chk({22'h0, lpf}, {22'h0, e});
						chk({22'h0, rate}, {22'h0, d[23:22]});
						chk({22'h0, gcode}, {22'h0, d[17:16]});
						chk({16'h0, vv}, 24'(20 << l));
						chk({22'h0, hpf, chg}, {22'h0, d[14], 1'h0});
					end
		$display("test lowpass done");
	endtask
	task t_reset;
		u_bcc_host.wr(7'h15, 24'h013000);
		u_bcc_host.rd(7'h15, q);
		chk(q, 24'h013000);
		@(negedge clk_i);
		clk_en_i = 1'h0;
		rst_n_i = 1'h0;
		@(negedge clk_i);
		rst_n_i = 1'h1;
		clk_en_i = 1'h1;
		u_bcc_host.rd(7'h14, q);
		chk(q, 24'h300000);
		u_bcc_host.rd(7'h15, q);
		chk(q, 24'h805000);
		chk({23'h0, chg}, 24'h0);
		$display("test reset done");
	endtask
	initial begin
		#1000000;
		fail_count++;
		test_done;
	end
	initial begin
		repeat (4) @(negedge clk_i);
		rst_n_i = 1'h1;
		t_mux;
		t_reset;
		t_lpf;
		test_done;
	end
endmodule
